// [core/tws_slave_rx.sv]
// two-wire slave receiver: address match, data reception, status codes, clock stretch
// Operation
// - own address is upper seven bits
// - address bit zero enables general call
// - match then direction bit zero receives
// - own address write sets event flag
// - lost arbitration then addressed gives 68/78
// - ack enable cleared gives NACK next
// - ack enable zero ignores own address
// - sleep still recognises address by bus
// - wake hold SCL until flag cleared
// - data register unreliable after sleep wake
// - status prescaler bits read as zero
// - status 60 after own write acked
// - status 68 after arbitration lost address
// - status 70 after general call acked
// - status 78 lost arbitration general call
// - status 80 own data byte acked
// - clear flag; ack enable chooses ACK
// - 88 cleared without ack: unaddressed, deaf
// - NACK state cleared with ack: listening
// - start request on leave: start later
// - status 90/98 general call data
// - status A0 on stop or restart
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_slave_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // master side hooks
  input wire logic arb_lost,
  // bus pins, enable low while driving low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // status pins
  output logic event_flag,
  output logic start_pending,
  output logic wake_req
);
  logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  tws_sync #(.STAGES(`TWS_SYNC_STAGES)) u_scl (
    .clk(clk), .rst_n(rst_n), .async_in(scl_in),
    .level_out(scl_s), .rise_out(scl_rise), .fall_out(scl_fall));
  tws_sync #(.STAGES(`TWS_SYNC_STAGES)) u_sda (
    .clk(clk), .rst_n(rst_n), .async_in(sda_in),
    .level_out(sda_s), .rise_out(sda_rise), .fall_out(sda_fall));

  logic start_cond, stop_cond;
  assign start_cond = sda_fall & scl_s;
  assign stop_cond = sda_rise & scl_s;

  tws_pkg::tws_state_type state_reg, state_next;
  logic [7:0] addr_reg, addr_next, ctrl_reg, ctrl_next, stat_reg, stat_next;
  logic [7:0] data_reg, data_next, shift_reg, shift_next, rdata_reg, rdata_next;
  logic [3:0] bit_reg, bit_next;
  logic gc_reg, gc_next, arb_reg, arb_next, ack_reg, ack_next;
  logic addressed_reg, addressed_next, deaf_reg, deaf_next;
  logic sleep_reg, sleep_next, wake_reg, wake_next, sta_pend_reg, sta_pend_next;
  logic sda_drv_reg, sda_drv_next, scl_drv_reg, scl_drv_next;

  function automatic logic [7:0] ctrl_word(input logic [7:0] cur, input logic [7:0] w);
    logic [7:0] v;
    v = cur;
    v[`TWS_CTRL_ACK] = w[`TWS_CTRL_ACK];
    v[`TWS_CTRL_STA] = w[`TWS_CTRL_STA];
    v[`TWS_CTRL_STO] = w[`TWS_CTRL_STO];
    v[`TWS_CTRL_EN] = w[`TWS_CTRL_EN];
    v[`TWS_CTRL_IE] = w[`TWS_CTRL_IE];
    v[`TWS_CTRL_WCOL] = 1'b0;
    return v;
  endfunction

  logic flag_clear, ack_en, enabled;
  assign flag_clear = reg_wr && reg_addr == `TWS_OFS_CTRL && reg_wdata[`TWS_CTRL_FLAG];
  assign ack_en = ctrl_reg[`TWS_CTRL_ACK];
  assign enabled = ctrl_reg[`TWS_CTRL_EN];

  always_comb begin
    logic own_hit, gc_hit, ev_set;
    logic [7:0] ev_code;
    own_hit = 1'b0;
    gc_hit = 1'b0;
    ev_set = 1'b0;
    ev_code = stat_reg;
    state_next = state_reg;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    data_next = data_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    gc_next = gc_reg;
    arb_next = arb_reg | arb_lost;
    ack_next = ack_reg;
    addressed_next = addressed_reg;
    deaf_next = deaf_reg;
    sleep_next = sleep_reg;
    wake_next = wake_reg;
    sta_pend_next = sta_pend_reg;
    sda_drv_next = sda_drv_reg;
    scl_drv_next = scl_drv_reg;
    rdata_next = 8'h00;

    // software side
    if (reg_wr) begin
      case (reg_addr)
        `TWS_OFS_ADDR: addr_next = reg_wdata;
        `TWS_OFS_CTRL: begin
          ctrl_next = ctrl_word(ctrl_reg, reg_wdata);
          if (reg_wdata[`TWS_CTRL_ACK]) begin
            deaf_next = 1'b0;
          end
        end
        `TWS_OFS_DATA: begin
          if (!ctrl_reg[`TWS_CTRL_FLAG]) begin
            ctrl_next[`TWS_CTRL_WCOL] = 1'b1;
          end else begin
            data_next = reg_wdata;
          end
        end
        `TWS_OFS_SLEEP: sleep_next = reg_wdata[0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `TWS_OFS_ADDR: rdata_next = addr_reg;
        `TWS_OFS_CTRL: rdata_next = ctrl_reg;
        `TWS_OFS_STAT: rdata_next = {stat_reg[7:3], 3'b000};
        `TWS_OFS_DATA: rdata_next = data_reg;
        `TWS_OFS_SLEEP: rdata_next = {7'h00, sleep_reg};
        default: rdata_next = 8'h00;
      endcase
    end

    // leaving an event state
    if (flag_clear && ctrl_reg[`TWS_CTRL_FLAG]) begin
      ctrl_next[`TWS_CTRL_FLAG] = 1'b0;
      wake_next = 1'b0;
      scl_drv_next = 1'b0;
      if (state_reg == tws_pkg::TWS_HOLD) begin
        if (addressed_reg) begin
          state_next = tws_pkg::TWS_DATA;
          ack_next = reg_wdata[`TWS_CTRL_ACK];
        end else begin
          state_next = tws_pkg::TWS_IDLE;
          deaf_next = ~reg_wdata[`TWS_CTRL_ACK];
          sta_pend_next = reg_wdata[`TWS_CTRL_STA];
        end
      end
    end
    if (sta_pend_reg && stop_cond) begin
      sta_pend_next = 1'b0;
    end

    // bus side
    case (state_reg)
      tws_pkg::TWS_IDLE: begin
        sda_drv_next = 1'b0;
        if (start_cond && enabled) begin
          state_next = tws_pkg::TWS_ADDR;
          bit_next = 4'h0;
        end
      end
      tws_pkg::TWS_ADDR, tws_pkg::TWS_DATA: begin
        if (scl_fall) begin
          sda_drv_next = 1'b0;
        end
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
        end
        if (bit_reg == 4'h8 && scl_fall) begin
          bit_next = 4'h0;
          if (state_reg == tws_pkg::TWS_ADDR) begin
            own_hit = shift_reg[7:1] == addr_reg[7:1];
            gc_hit = shift_reg[7:1] == 7'h00 && addr_reg[`TWS_ADDR_GCE];
            if ((own_hit || gc_hit) && !shift_reg[0] && ack_en && !deaf_reg) begin
              gc_next = gc_hit & ~own_hit;
              sda_drv_next = 1'b1;
              state_next = tws_pkg::TWS_ACK_ADDR;
            end else begin
              state_next = tws_pkg::TWS_SKIP;
            end
          end else begin
            sda_drv_next = ack_reg;
            state_next = tws_pkg::TWS_ACK_DATA;
          end
        end
        if (start_cond || stop_cond) begin
          if (state_reg == tws_pkg::TWS_DATA) begin
            ev_set = 1'b1;
            ev_code = `TWS_ST_STOP;
            scl_drv_next = 1'b1;
            addressed_next = 1'b0;
            state_next = tws_pkg::TWS_HOLD;
          end else begin
            state_next = start_cond ? tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
            bit_next = 4'h0;
          end
        end
      end
      tws_pkg::TWS_ACK_ADDR, tws_pkg::TWS_ACK_DATA: begin
        if (scl_fall) begin
          sda_drv_next = 1'b0;
          ev_set = 1'b1;
          scl_drv_next = 1'b1;
          state_next = tws_pkg::TWS_HOLD;
          if (state_reg == tws_pkg::TWS_ACK_ADDR) begin
            addressed_next = 1'b1;
            arb_next = 1'b0;
            ack_next = ack_en;
            wake_next = sleep_reg;
            if (gc_reg) begin
              ev_code = arb_reg ? `TWS_ST_ARB_GC : `TWS_ST_GC;
            end else begin
              ev_code = arb_reg ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W;
            end
          end else begin
            data_next = shift_reg;
            addressed_next = ack_reg;
            if (gc_reg) begin
              ev_code = ack_reg ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
            end else begin
              ev_code = ack_reg ? `TWS_ST_OWN_ACK : `TWS_ST_OWN_NACK;
            end
          end
        end
      end
      tws_pkg::TWS_HOLD: begin
        // all bus events, start/stop included, wait for software
        if (!addressed_reg && !ctrl_reg[`TWS_CTRL_FLAG] && !ev_set) begin
          state_next = tws_pkg::TWS_IDLE;
        end
      end
      tws_pkg::TWS_SKIP: begin
        if (start_cond) begin
          state_next = tws_pkg::TWS_ADDR;
          bit_next = 4'h0;
        end else if (stop_cond) begin
          state_next = tws_pkg::TWS_IDLE;
        end
      end
      default: state_next = tws_pkg::TWS_IDLE;
    endcase

    // set wins over a same-cycle clear
    if (ev_set) begin
      ctrl_next[`TWS_CTRL_FLAG] = 1'b1;
      stat_next = ev_code;
    end else if (flag_clear && ctrl_reg[`TWS_CTRL_FLAG]) begin
      stat_next = `TWS_ST_IDLE;
    end
    if (!ctrl_next[`TWS_CTRL_EN]) begin
      state_next = tws_pkg::TWS_IDLE;
      sda_drv_next = 1'b0;
      scl_drv_next = 1'b0;
      addressed_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= tws_pkg::TWS_IDLE;
      addr_reg <= `TWS_RST_ADDR;
      ctrl_reg <= `TWS_RST_CTRL;
      stat_reg <= `TWS_ST_IDLE;
      data_reg <= `TWS_RST_DATA;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      gc_reg <= 1'b0;
      arb_reg <= 1'b0;
      ack_reg <= 1'b0;
      addressed_reg <= 1'b0;
      deaf_reg <= 1'b0;
      sleep_reg <= 1'b0;
      wake_reg <= 1'b0;
      sta_pend_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      scl_drv_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      data_reg <= data_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      gc_reg <= gc_next;
      arb_reg <= arb_next;
      ack_reg <= ack_next;
      addressed_reg <= addressed_next;
      deaf_reg <= deaf_next;
      sleep_reg <= sleep_next;
      wake_reg <= wake_next;
      sta_pend_reg <= sta_pend_next;
      sda_drv_reg <= sda_drv_next;
      scl_drv_reg <= scl_drv_next;
      rdata_reg <= rdata_next;
    end
  end

  // open drain: output level is always low, enable low while pulling
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drv_reg;
  assign sda_oe_n = ~sda_drv_reg;
  assign reg_rdata = rdata_reg;
  assign event_flag = ctrl_reg[`TWS_CTRL_FLAG];
  assign start_pending = sta_pend_reg;
  assign wake_req = wake_reg;
endmodule // tws_slave_rx

// [core/tws_defs.svh]
// register offsets, field positions, reset values, status codes and synchroniser stage count
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_OFS_ADDR 3'h0
`define TWS_OFS_CTRL 3'h1
`define TWS_OFS_STAT 3'h2
`define TWS_OFS_DATA 3'h3
`define TWS_OFS_SLEEP 3'h4
`define TWS_CTRL_FLAG 7
`define TWS_CTRL_ACK 6
`define TWS_CTRL_STA 5
`define TWS_CTRL_STO 4
`define TWS_CTRL_WCOL 3
`define TWS_CTRL_EN 2
`define TWS_CTRL_IE 0
`define TWS_ADDR_GCE 0
`define TWS_RST_ADDR 8'hFE
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'hFF
`define TWS_ST_IDLE 8'hF8
`define TWS_ST_OWN_W 8'h60
`define TWS_ST_ARB_OWN_W 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_OWN_ACK 8'h80
`define TWS_ST_OWN_NACK 8'h88
`define TWS_ST_GC_ACK 8'h90
`define TWS_ST_GC_NACK 8'h98
`define TWS_ST_STOP 8'hA0
`define TWS_SYNC_STAGES 2
`endif

// [core/tws_pkg.sv]
// types of the two-wire slave receiver
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_ACK_ADDR = 3'b010,
    TWS_DATA = 3'b011,
    TWS_ACK_DATA = 3'b100,
    TWS_HOLD = 3'b101,
    TWS_SKIP = 3'b110
  } tws_state_type;
endpackage

// [core/tws_sync.sv]
// two-flop synchroniser with edge outputs taken from the settled stages
`timescale 1ns/1ps
module tws_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin side
  input wire logic async_in,
  // synchronised side
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic [STAGES:0] pipe_reg;
  logic [STAGES:0] pipe_next;

  // fewer than two stages would let a metastable level reach the logic
  if (STAGES < 2) begin : g_bad_stages
    $error("tws_sync needs at least two stages");
  end

  always_comb begin
    pipe_next = {pipe_reg[STAGES-1:0], async_in};
  end

  // pins idle high on a two-wire bus, so reset to high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_reg <= '1;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  assign level_out = pipe_reg[STAGES-1];
  assign rise_out = pipe_reg[STAGES-1] & ~pipe_reg[STAGES];
  assign fall_out = ~pipe_reg[STAGES-1] & pipe_reg[STAGES];
endmodule // tws_sync

// [testbench/tws_slave_rx_properties.sv]
// concurrent checks on the two-wire slave receiver ports
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_slave_rx_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // bus and status
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic event_flag,
  input wire logic wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  stretch_hold_a: assert property (event_flag && $past(event_flag) |-> !scl_oe_n)
    else $error("scl released while flag set");
  flag_clear_a: assert property (reg_wr && reg_addr == `TWS_OFS_CTRL
    && reg_wdata[`TWS_CTRL_FLAG] && event_flag |-> ##[1:3] (!event_flag && scl_oe_n))
    else $error("flag clear did not release scl");
  flag_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `TWS_OFS_CTRL
    |-> reg_rdata[`TWS_CTRL_FLAG] == $past(event_flag)) else $error("flag bit mismatch");
  status_low_a: assert property ($past(reg_rd) && $past(reg_addr) == `TWS_OFS_STAT
    |-> reg_rdata[2:0] == 3'h0) else $error("status low bits not zero");
  ack_flag_a: assert property (!sda_oe_n |-> !event_flag)
    else $error("sda pulled while flag set");
  ack_len_a: assert property ($fell(sda_oe_n) |-> ##[1:24] sda_oe_n)
    else $error("ack held too long");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
  wake_hold_a: assert property (wake_req && event_flag |-> !scl_oe_n)
    else $error("scl released during wake");
  wake_end_a: assert property ($fell(event_flag) |-> ##[0:1] !wake_req)
    else $error("wake request outlived flag");
  cover property ($rose(event_flag));
  cover property ($rose(wake_req));
  cover property ($fell(sda_oe_n));
endmodule // tws_slave_rx_properties

// [testbench/tws_bus_master.sv]
// behavioural two-wire bus master on open-drain lines, 400 ns bit time
`timescale 1ns/1ps
module tws_bus_master (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // master pulls, 1 = released
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_x(input logic b, output logic s);
    sda_m = b;
    #100;
    scl_m = 1'b1;
    // a stretching slave may hold scl as long as it likes
    wait (scl === 1'b1);
    #200;
    s = sda;
    scl_m = 1'b0;
    #100;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, ack);
  endtask
  task automatic start_c();
    #17;
    sda_m = 1'b1;
    #100;
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #100;
    sda_m = 1'b0;
    #100;
    scl_m = 1'b0;
    #100;
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    #100;
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #100;
    sda_m = 1'b1;
    #200;
  endtask
endmodule // tws_bus_master

// [testbench/test_tws_slave_rx.sv]
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`include "tws_defs.svh"
module test_tws_slave_rx;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic arb_lost = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, event_flag, start_pending, wake_req;
  logic scl_m, sda_m, scl, sda, ack;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [6:0] own;
  logic [7:0] d0, d1;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  integer seed = 32'h0178;
  always #25 clk = ~clk;
  // pull-ups: low when any party pulls
  assign scl = scl_m & (scl_oe_n | scl_out);
  assign sda = sda_m & (sda_oe_n | sda_out);
  tws_slave_rx tws_slave_rx_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arb_lost(arb_lost), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .event_flag(event_flag),
    .start_pending(start_pending), .wake_req(wake_req));
  tws_bus_master tws_bus_master_inst (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    cyc++;
    if (rd_d && exp_q.size() > 0) begin
      check(reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic evt(input logic [7:0] st, input logic [7:0] c);
    for (int i = 0; i < 300 && event_flag !== 1'b1; i++) begin
      @(posedge clk);
    end
    check({7'h0, event_flag}, 8'h01);
    rd(`TWS_OFS_STAT, st);
    if (c != 8'h00) begin
      wr(`TWS_OFS_CTRL, c);
    end
  endtask
  task automatic frame(input logic [7:0] d, input logic e);
    tws_bus_master_inst.send_byte(d, ack);
    check({7'h0, ack}, {7'h0, e});
  endtask
  task automatic st();
    tws_bus_master_inst.start_c();
  endtask
  task automatic sp();
    tws_bus_master_inst.stop_c();
  endtask
  task automatic arb();
    @(posedge clk);
    arb_lost <= 1'b1;
    @(posedge clk);
    arb_lost <= 1'b0;
  endtask
  initial begin
    own = 7'($random(seed)) | 7'h10;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TWS_OFS_ADDR, `TWS_RST_ADDR);
    rd(`TWS_OFS_CTRL, `TWS_RST_CTRL);
    rd(`TWS_OFS_STAT, `TWS_ST_IDLE);
    rd(`TWS_OFS_DATA, `TWS_RST_DATA);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    $display("test reset done");
    wr(`TWS_OFS_ADDR, {own, 1'b1});
    wr(`TWS_OFS_CTRL, 8'h44);
    st();
    frame({own, 1'b0}, 1'b0);
    evt(`TWS_ST_OWN_W, 8'hC4);
    frame(d0, 1'b0);
    evt(`TWS_ST_OWN_ACK, 8'h00);
    rd(`TWS_OFS_DATA, d0);
    wr(`TWS_OFS_CTRL, 8'h84);
    frame(d1, 1'b1);
    evt(`TWS_ST_OWN_NACK, 8'h84);
    sp();
    st();
    frame({own, 1'b0}, 1'b1);
    sp();
    wr(`TWS_OFS_CTRL, 8'h44);
    $display("test own address done");
    st();
    frame(8'h00, 1'b0);
    evt(`TWS_ST_GC, 8'hC4);
    frame(d1, 1'b0);
    evt(`TWS_ST_GC_ACK, 8'hC4);
    sp();
    evt(`TWS_ST_STOP, 8'hE4);
    @(negedge clk);
    check({7'h0, start_pending}, 8'h01);
    wr(`TWS_OFS_CTRL, 8'h44);
    st();
    sp();
    repeat (8) @(negedge clk);
    check({7'h0, start_pending}, 8'h00);
    $display("test general call done");
    arb();
    st();
    frame({own, 1'b0}, 1'b0);
    evt(`TWS_ST_ARB_OWN_W, 8'hC4);
    sp();
    evt(`TWS_ST_STOP, 8'hC4);
    arb();
    st();
    frame(8'h00, 1'b0);
    evt(`TWS_ST_ARB_GC, 8'h84);
    frame(d0, 1'b1);
    evt(`TWS_ST_GC_NACK, 8'hC4);
    st();
    frame({own, 1'b0}, 1'b0);
    evt(`TWS_ST_OWN_W, 8'hC4);
    sp();
    evt(`TWS_ST_STOP, 8'hC4);
    $display("test arbitration done");
    wr(`TWS_OFS_ADDR, {own, 1'b0});
    st();
    frame(8'h00, 1'b1);
    st();
    frame({own ^ 7'h01, 1'b0}, 1'b1);
    sp();
    $display("test address filter done");
    wr(`TWS_OFS_SLEEP, 8'h01);
    st();
    frame({own, 1'b0}, 1'b0);
    evt(`TWS_ST_OWN_W, 8'h00);
    @(negedge clk);
    check({7'h0, wake_req}, 8'h01);
    check({7'h0, scl}, 8'h00);
    wr(`TWS_OFS_SLEEP, 8'h00);
    wr(`TWS_OFS_CTRL, 8'hC4);
    @(negedge clk);
    check({7'h0, wake_req}, 8'h00);
    sp();
    evt(`TWS_ST_STOP, 8'hC4);
    $display("test sleep wake done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // test_tws_slave_rx
bind tws_slave_rx tws_slave_rx_properties chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .event_flag(event_flag), .wake_req(wake_req));
